// File: verilog/rx_cas_pkg.sv
// Constants for the receive channel-associated signaling buffer.
package rx_cas_pkg;
  localparam logic [7:0] REG_CTRL = 8'h64;
  localparam logic [7:0] REG_BUSY = 8'h65;
  localparam logic [7:0] REG_ADDR = 8'h66;
  localparam logic [7:0] REG_DATA = 8'h67;
  localparam int BIT_FLAG_MODE = 6;
  localparam int BIT_IRQ_EN = 5;
  localparam int BIT_CFG_EN = 0;
  localparam int BIT_BUSY = 7;
  localparam int BIT_RNW = 7;
  localparam logic [4:0] TS_SIG = 5'h10;
  localparam logic [1:0] SEG_CUR = 2'h0;
  localparam logic [1:0] SEG_DLY = 2'h1;
  localparam logic [1:0] SEG_BOUNCE = 2'h2;
  localparam logic [3:0] MF_FIRST = 4'h1;
  localparam logic [3:0] MF_LAST = 4'hf;
  localparam logic [3:0] MF_ALIGN = 4'h0;
  localparam int ACCESS_NS = 490;
  localparam int CLK_NS = 25;
  localparam logic [4:0] ACCESS_CYCLES = 5'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
endpackage

// File: verilog/rx_cas_buffer.sv
// Receive CAS buffer: extraction, debounce, freeze, change flags and indirect window.
`timescale 1ns/10ps
module rx_cas_buffer import rx_cas_pkg::*; (
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] WDATA_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic RX_TS_VALID_IN,
  input wire logic [4:0] RX_TS_NUM_IN,
  input wire logic [3:0] RX_MF_FRAME_IN,
  input wire logic [7:0] RX_OCTET_IN,
  input wire logic SMF_SYNC_IN,
  input wire logic UNFRAMED_IN,
  input wire logic EXT_SIG_MODE_IN,
  input wire logic SYS_TS_STROBE_IN,
  input wire logic [4:0] SYS_TS_NUM_IN,
  output logic [3:0] RX_SIGNALING_OUT,
  output logic INT_N_OUT
);

  typedef struct packed {
    logic [31:0][3:0] sig;
    logic [31:0][3:0] dly;
    logic [31:0][3:0] prv;
    // Per-timeslot debounce selection, written through the indirect window.
    logic [31:0] bounce;
    logic [30:1] chg;
    logic flag_mode;
    logic irq_en;
    logic cfg_en;
    logic [6:0] iaddr;
    logic rnw;
    logic [7:0] idata;
    logic busy;
    logic [4:0] bcnt;
    logic [7:0] rdata;
    logic int_n;
    logic [3:0] sigout;
  } state_s;

  state_s q;
  state_s d;
  logic take_sig;
  logic mf_align;
  logic [3:0] sel_sig;

  // ==========================================================
  // Stream qualification.
  // Timeslot 16 only, and only while in sync and framed.
  assign take_sig = RX_TS_VALID_IN && RX_TS_NUM_IN == TS_SIG && SMF_SYNC_IN && !UNFRAMED_IN;
  assign mf_align = take_sig && RX_MF_FRAME_IN == MF_ALIGN;
  assign sel_sig = q.sig[SYS_TS_NUM_IN];

  // ==========================================================
  // Next state.
  always_comb begin
    logic [4:0] ts;
    logic [4:0] fl;
    logic [3:0] nib;
    logic [6:0] ia;
    ts = 5'h0;
    fl = 5'h0;
    nib = 4'h0;
    ia = q.iaddr;
    d = q;
    // Register reads, with read-to-clear of the change flags.
    if (RD_IN) begin
      case (ADDR_IN)
        REG_CTRL: d.rdata = q.flag_mode ? {2'b01, q.chg[30:25]} :
                            {1'b0, 1'b0, q.irq_en, 4'h0, q.cfg_en};
        REG_BUSY: d.rdata = q.flag_mode ? q.chg[24:17] : {q.busy, 7'h0};
        REG_ADDR: d.rdata = q.flag_mode ? q.chg[16:9] : {q.rnw, q.iaddr};
        REG_DATA: d.rdata = q.flag_mode ? q.chg[8:1] : q.idata;
        default: d.rdata = 8'h00;
      endcase
      if (q.flag_mode) begin
        case (ADDR_IN)
          REG_CTRL: d.chg[30:25] = 6'h0;
          REG_BUSY: d.chg[24:17] = 8'h0;
          REG_ADDR: d.chg[16:9] = 8'h0;
          REG_DATA: d.chg[8:1] = 8'h0;
          default: d.chg = q.chg;
        endcase
      end
    end
    // Register writes.
    if (WR_IN) begin
      if (ADDR_IN == REG_CTRL) begin
        d.flag_mode = WDATA_IN[BIT_FLAG_MODE];
        d.irq_en = WDATA_IN[BIT_IRQ_EN];
        d.cfg_en = WDATA_IN[BIT_CFG_EN];
      end
      // Address write launches the indirect access.
      if (!q.flag_mode && !q.busy && ADDR_IN == REG_ADDR) begin
        d.iaddr = WDATA_IN[6:0];
        d.rnw = WDATA_IN[BIT_RNW];
        d.busy = 1'b1;
        d.bcnt = ACCESS_CYCLES;
      end
      if (!q.flag_mode && !q.busy && ADDR_IN == REG_DATA) begin
        d.idata = WDATA_IN;
      end
    end
    // Busy counts down the access cycle, then the access lands.
    if (q.busy) begin
      d.bcnt = q.bcnt - 5'd1;
      if (q.bcnt == 5'd1) begin
        d.busy = 1'b0;
        // Segment decode of the indirect space.
        if (q.rnw) begin
          case (ia[6:5])
            SEG_CUR: d.idata = {4'h0, q.sig[ia[4:0]]};
            SEG_DLY: d.idata = {4'h0, q.dly[ia[4:0]]};
            SEG_BOUNCE: d.idata = {7'h0, q.bounce[ia[4:0]]};
            default: d.idata = 8'h00;
          endcase
        end else if (ia[6:5] == SEG_BOUNCE) begin
          d.bounce[ia[4:0]] = q.idata[0];
        end
      end
    end
    // Delayed copy refreshes once a multiframe.
    if (mf_align) begin
      d.dly = q.sig;
    end
    // Received, previous and accepted values per timeslot.
    if (take_sig && RX_MF_FRAME_IN >= MF_FIRST && RX_MF_FRAME_IN <= MF_LAST) begin
      for (int k = 0; k < 2; k++) begin
        ts = (k == 0) ? {1'b0, RX_MF_FRAME_IN} : {1'b1, RX_MF_FRAME_IN};
        // A..D land in the low nibble.
        nib = (k == 0) ? RX_OCTET_IN[7:4] : RX_OCTET_IN[3:0];
        fl = ts[4] ? ts - 5'd1 : ts;
        d.prv[ts] = nib;
        // Debounced slots need two equal values.
        if (!(q.cfg_en && q.bounce[ts]) || q.prv[ts] == nib) begin
          if (nib != q.sig[ts]) begin
            d.sig[ts] = nib;
            // Set wins over a same-cycle read clear.
            d.chg[fl] = 1'b1;
          end
        end
      end
    end
    // Interrupt from any flag when enabled.
    d.int_n = !(d.irq_en && |d.chg);
    // Signaling nibble follows its timeslot out.
    if (SYS_TS_STROBE_IN) begin
      d.sigout = EXT_SIG_MODE_IN ? sel_sig : 4'h0;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      q <= '0;
      q.int_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign RDATA_OUT = q.rdata;
  assign RX_SIGNALING_OUT = q.sigout;
  assign INT_N_OUT = q.int_n;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  // Busy stands twenty clocks, and the window refuses a new launch meanwhile.
  busy_hold_a: assert property ($rose(q.busy) |-> q.busy [*8] ##12 q.busy ##1 !q.busy)
    else $error("Busy did not last the access cycle.");
  busy_refuse_a: assert property (
    (q.busy && WR_IN && ADDR_IN == REG_ADDR) |=> $stable(q.iaddr) && $stable(q.rnw))
    else $error("Indirect address changed during an access.");
  busy_mode_a: assert property ($rose(q.busy) |-> $past(!q.flag_mode))
    else $error("Indirect access started in change-flag mode.");
  seg_read_a: assert property (
    (q.busy && q.bcnt == 5'd1 && q.rnw && q.iaddr[6:5] == SEG_CUR)
    |=> q.idata == {4'h0, $past(q.sig[q.iaddr[4:0]])})
    else $error("Indirect read did not return the current segment.");

  // Extraction, freeze and the delayed copy.
  sig_freeze_a: assert property ((!SMF_SYNC_IN || UNFRAMED_IN) |=> $stable(q.sig))
    else $error("Signaling moved while frozen.");
  sig_extract_a: assert property ((take_sig && !q.cfg_en && RX_MF_FRAME_IN == 4'h3)
    |=> q.sig[3] == $past(RX_OCTET_IN[7:4]) && q.sig[19] == $past(RX_OCTET_IN[3:0]))
    else $error("Timeslot 16 nibbles not stored.");
  dly_copy_a: assert property (mf_align |=> q.dly == $past(q.sig))
    else $error("Delayed copy not refreshed.");

  // Change flags and the interrupt level.
  chg_set_a: assert property ($changed(q.sig) |-> |q.chg)
    else $error("Signaling change left no flag.");
  int_level_a: assert property (INT_N_OUT == !(q.irq_en && |q.chg))
    else $error("Interrupt level does not follow the enabled flags.");
  flag_sticky_a: assert property ((q.chg[3] && !RD_IN) |=> q.chg[3])
    else $error("Change flag dropped without a read.");

  // Debounce and the system-side nibble.
  bounce_two_a: assert property (($changed(q.sig[4]) && $past(q.cfg_en && q.bounce[4]))
    |-> q.sig[4] == $past(q.prv[4]))
    else $error("Debounced slot updated on a single value.");
  sig_out_a: assert property ((SYS_TS_STROBE_IN && EXT_SIG_MODE_IN)
    |=> RX_SIGNALING_OUT == $past(sel_sig))
    else $error("Signaling nibble not aligned with timeslot.");
  sig_quiet_a: assert property ((SYS_TS_STROBE_IN && !EXT_SIG_MODE_IN)
    |=> RX_SIGNALING_OUT == 4'h0)
    else $error("Signaling nibble driven outside external mode.");

  // Covers for the main scenarios.
  access_c: cover property ($rose(q.busy) ##20 !q.busy);
  irq_c: cover property ($fell(INT_N_OUT));
  copy_c: cover property (mf_align ##1 $changed(q.dly));
  bounce_c: cover property (q.cfg_en && q.bounce[4] && $changed(q.sig[4]));
  freeze_c: cover property (RX_TS_VALID_IN && !SMF_SYNC_IN);

endmodule

// File: tb/sys_side_model.sv
// System-side model that requests and captures timeslot signaling.
`timescale 1ns/10ps
module sys_side_model (
  input wire logic clk_in,
  input wire logic [3:0] sig_in,
  output logic strobe_out,
  output logic [4:0] num_out
);
  initial begin
    strobe_out = 1'b0;
    num_out = 5'h1f;
  end
  task automatic fetch(input logic [4:0] ts, output logic [3:0] v);
    @(negedge clk_in);
    strobe_out = 1'b1;
    num_out = ts;
    @(negedge clk_in);
    strobe_out = 1'b0;
    num_out = ~ts;
    v = sig_in;
  endtask
endmodule

// File: tb/receive_cas_signaling_buffer_tb.sv
// Self-checking bench for the receive CAS buffer.
`timescale 1ns/10ps
module receive_cas_signaling_buffer_tb import rx_cas_pkg::*;;
  typedef struct packed {logic [3:0] f; logic [7:0] o; logic [7:0] a; logic [7:0] x;} row_s;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tsv = 1'b0;
  logic sync = 1'b1, unf = 1'b0, ext = 1'b0, stb, int_n;
  logic [7:0] addr = 8'h00, wd = 8'h00, oct = 8'h00, rdat, v;
  logic [4:0] stn, tsn = TS_SIG;
  logic [3:0] mf = 4'h0, sig, s;
  int errors = 0, n_checks = 0, polls = 0;
  row_s rows [4] = '{'{4'h3, 8'h5A, 8'h83, 8'h05}, '{4'h3, 8'h5A, 8'h93, 8'h0A},
    '{4'hF, 8'hC1, 8'h8F, 8'h0C}, '{4'hF, 8'hC1, 8'h9F, 8'h01}};
  logic [7:0] fx [4] = '{8'h60, 8'h02, 8'h40, 8'h04};
  always #12.5 clk = ~clk;
  rx_cas_buffer rx_cas_buffer_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WR_IN(wr), .RD_IN(rd), .WDATA_IN(wd), .RDATA_OUT(rdat), .RX_TS_VALID_IN(tsv),
    .RX_TS_NUM_IN(tsn), .RX_MF_FRAME_IN(mf), .RX_OCTET_IN(oct), .SMF_SYNC_IN(sync),
    .UNFRAMED_IN(unf), .EXT_SIG_MODE_IN(ext), .SYS_TS_STROBE_IN(stb),
    .SYS_TS_NUM_IN(stn), .RX_SIGNALING_OUT(sig), .INT_N_OUT(int_n));
  sys_side_model sys_side_model_i (.clk_in(clk), .sig_in(sig), .strobe_out(stb),
    .num_out(stn));
  // ======================================================
  // Bus and stream tasks.
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(logic [7:0] a, logic w, logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    @(negedge clk);
    q = rdat;
  endtask
  task automatic ind(logic [7:0] cmd, output logic [7:0] q);
    int i;
    bus(REG_ADDR, 1'b1, cmd, q);
    for (i = 0; i < 40; i++) begin
      bus(REG_BUSY, 1'b0, 8'h00, q);
      if (q[BIT_BUSY] === 1'b0) break;
    end
    polls = i;
    bus(REG_DATA, 1'b0, 8'h00, q);
  endtask
  task automatic frame(logic [3:0] f, logic [7:0] o);
    @(negedge clk);
    tsv = 1'b1;
    mf = f;
    oct = o;
    @(negedge clk);
    tsv = 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ======================================================
  // Watchdog and main sequence.
  initial begin
    #500000;
    errors++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk("int_n", {7'h0, int_n}, 8'h01);
    bus(REG_CTRL, 1'b1, 8'h20, v);
    foreach (rows[i]) begin
      frame(rows[i].f, rows[i].o);
      ind(rows[i].a, v);
      chk("entry", v, rows[i].x);
    end
    chk("busy", 8'(polls > 4 && polls < 9), 8'h01);
    chk("int_n", {7'h0, int_n}, 8'h00);
    for (int k = 0; k < 2; k++) begin
      sync = k[0];
      unf = k[0];
      frame(4'h3, 8'hFF);
      ind(8'h83, v);
      chk("frozen", v, 8'h05);
    end
    sync = 1'b1;
    unf = 1'b0;
    tsn = 5'h05;
    frame(4'h3, 8'hFF);
    tsn = TS_SIG;
    ind(8'h83, v);
    chk("other ts", v, 8'h05);
    frame(4'h0, 8'h00);
    ind(8'hA3, v);
    chk("delayed", v, 8'h05);
    ext = 1'b1;
    sys_side_model_i.fetch(5'h0F, s);
    chk("sys sig", {4'h0, s}, 8'h0C);
    ext = 1'b0;
    sys_side_model_i.fetch(5'h0F, s);
    chk("no ext", {4'h0, s}, 8'h00);
    bus(REG_CTRL, 1'b1, 8'h60, v);
    for (int k = 0; k < 4; k++) begin
      bus(REG_CTRL + 8'(k), 1'b0, 8'h00, v);
      chk("flags", v, fx[k]);
    end
    bus(REG_DATA, 1'b0, 8'h00, v);
    chk("cleared", v, 8'h00);
    chk("int_n", {7'h0, int_n}, 8'h01);
    bus(REG_CTRL, 1'b1, 8'h01, v);
    bus(REG_DATA, 1'b1, 8'h01, v);
    ind(8'h44, v);
    for (int k = 0; k < 2; k++) begin
      frame(4'h4, 8'h30);
      ind(8'h84, v);
      chk("debounce", v, k ? 8'h03 : 8'h00);
    end
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("int_n", {7'h0, int_n}, 8'h01);
    bus(REG_CTRL, 1'b0, 8'h00, v);
    chk("ctrl", v, 8'h00);
    ind(8'h84, v);
    chk("cleared sig", v, 8'h00);
    final_report();
  end
endmodule
